// file: logic/rectifier_mgmt_consts.svh
// Constants of the rectifier management command unit: codes, limits, timing counts.
// Assumes a 200 MHz reference clock; included by the package, the command unit and the testbench files.
`ifndef RECTIFIER_MGMT_CONSTS_SVH
`define RECTIFIER_MGMT_CONSTS_SVH

`define CMD_CLEAR_FAULTS   8'h03
`define CMD_ISO_TEST       8'hDA
`define CMD_READ_INPUT     8'hDC
`define CMD_READ_FW_REV    8'hDD
`define CMD_READ_RUN_TIMER 8'hDE
`define CMD_FAN_SET        8'hDF
`define CMD_FAN_NORMAL     8'hE0
`define CMD_READ_FAN       8'hE1
`define CMD_CLOCK_HOLD     8'hE2

`define INPUT_BYTE_COUNT   8'h04
`define FAN_BYTE_COUNT     8'h05
`define VIN_OFFSET_V       9'h04B
`define FAN_DUTY_MAX       8'h64
`define REV_NONE           8'h00
`define FAN_ABSENT         8'h00

`define CLK_PERIOD_NS      5
`define HOLD_TIME_NS       25000000
`define HOLD_CYCLES        (`HOLD_TIME_NS / `CLK_PERIOD_NS)
`define BLINK_HALF_NS      250000000
`define BLINK_CYCLES       (`BLINK_HALF_NS / `CLK_PERIOD_NS)
`define CLEAR_SETTLE_CYC   16

`endif

// file: logic/rectifier_mgmt_pkg.sv
// Types shared by the rectifier management command unit.
// Assumes the constants header sits beside it.
`include "rectifier_mgmt_consts.svh"

package rectifier_mgmt_pkg;

  // Byte-level events from the serial link layer
  typedef struct packed {
    logic       cmd;
    logic       wr;
    logic       rd;
    logic       stop;
    logic [7:0] data;
  } link_req_t;

  // Read byte returned to the link layer, which appends PEC after last
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } link_rsp_t;

  // Monitored values from same-clock supervisory logic
  typedef struct packed {
    logic [8:0]  vin_volts;
    logic [15:0] pin_watts;
    logic [2:0]  fw_ok;
    logic [23:0] fw_rev;
    logic [23:0] run_hours;
    logic [7:0]  thermal_duty;
    logic [2:0]  fan_fitted;
    logic [23:0] fan_speed;
    logic [15:0] status;
    logic        internal_fault;
    logic        external_fault;
  } monitor_t;

  typedef enum logic [1:0] {
    st_idle,
    st_fan_data,
    st_no_data
  } cmd_state_t;

endpackage

// file: logic/cycle_timer.sv
// Loadable down-counter that reports busy until its count runs out.
// Assumes a single clock with the unit's clock enable.
`timescale 1ns/10ps

module cycle_timer #(
  parameter int WIDTH = 26
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_ce,
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_count,
  output logic                  o_busy
);

  logic [WIDTH-1:0] remain;
  wire              running = (remain != '0);

  // Load wins over the running count
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      remain <= '0;
    end else if (i_ce) begin
      if (i_load) begin
        remain <= i_count;
      end else if (running) begin
        remain <= remain - 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_busy <= 1'b0;
    end else if (i_ce) begin
      o_busy <= i_load | (remain > 1);
    end
  end

endmodule

// file: logic/rectifier_mgmt_command_unit.sv
// Management command handler of the rectifier's serial management slave.
// Assumes a link layer on the same clock that frames bytes and appends PEC,
// and asynchronous pins for mains, aux bias, module presence and input state.
`timescale 1ns/10ps
`include "rectifier_mgmt_consts.svh"

module rectifier_mgmt_command_unit #(
  parameter int HOLD_CYCLES  = `HOLD_CYCLES,
  parameter int BLINK_CYCLES = `BLINK_CYCLES,
  parameter int SETTLE_CYC   = `CLEAR_SETTLE_CYC
) (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_rstn,
  input  wire logic                          i_ce,
  input  wire rectifier_mgmt_pkg::link_req_t i_link,
  input  wire rectifier_mgmt_pkg::monitor_t  i_mon,
  input  wire logic                          i_status_read,
  input  wire logic                          i_mains_ok,
  input  wire logic                          i_aux_bias_rail_a,
  input  wire logic                          i_aux_bias_rail_b,
  input  wire logic                          i_module_present,
  input  wire logic                          i_vin_present,
  input  wire logic                          i_vin_out_of_range,
  output rectifier_mgmt_pkg::link_rsp_t      o_rsp,
  output logic [7:0]                         o_fan_duty,
  output logic [15:0]                        o_status,
  output logic                               o_unsupported,
  output logic                               o_iso_test_start,
  output logic                               o_clear_faults,
  output logic                               o_scl_hold,
  output logic                               o_fault_pin,
  output logic                               o_input_led,
  output logic                               o_smbalert_o,
  output logic                               o_smbalert_oe
);
  import rectifier_mgmt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Voltage less the fixed offset, saturated into one byte
  function automatic logic [7:0] vin_byte(input logic [8:0] volts);
    logic [8:0] diff;
    diff = volts - `VIN_OFFSET_V;
    if (volts < `VIN_OFFSET_V) begin
      vin_byte = 8'h00;
    end else if (diff[8]) begin
      vin_byte = 8'hFF;
    end else begin
      vin_byte = diff[7:0];
    end
  endfunction

  // Revision byte or zero when not reportable
  function automatic logic [7:0] rev_byte(input logic ok, input logic [7:0] bcd);
    rev_byte = ok ? bcd : `REV_NONE;
  endfunction

  // Fan speed byte or zero when the position is empty
  function automatic logic [7:0] fan_byte(input logic fitted, input logic [7:0] speed);
    fan_byte = fitted ? speed : `FAN_ABSENT;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  wire  [4:0] pin_raw = {i_mains_ok, i_aux_bias_rail_a | i_aux_bias_rail_b, i_module_present,
                         i_vin_present, i_vin_out_of_range};

  // Two flops before any logic looks at a pin, except the OR of the two aux bias rails ahead of them
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else if (i_ce) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire mains_s   = pin_sync[4];
  wire aux_s     = pin_sync[3];
  wire present_s = pin_sync[2];
  wire vin_pres  = pin_sync[1];
  wire vin_oor   = pin_sync[0];

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  wire [7:0] code       = i_link.data;
  wire       is_clear   = (code == `CMD_CLEAR_FAULTS);
  wire       is_iso     = (code == `CMD_ISO_TEST);
  wire       is_input   = (code == `CMD_READ_INPUT);
  wire       is_fw      = (code == `CMD_READ_FW_REV);
  wire       is_timer   = (code == `CMD_READ_RUN_TIMER);
  wire       is_fan_set = (code == `CMD_FAN_SET);
  wire       is_fan_nrm = (code == `CMD_FAN_NORMAL);
  wire       is_fan_rd  = (code == `CMD_READ_FAN);
  wire       is_hold    = (code == `CMD_CLOCK_HOLD);
  wire       known      = is_clear | is_iso | is_input | is_fw | is_timer | is_fan_set |
                          is_fan_nrm | is_fan_rd | is_hold;
  wire       cmd_ev     = i_link.cmd;
  wire       wr_ev      = i_link.wr;

  cmd_state_t state;
  cmd_state_t next_state;

  // Data byte expectations after a command
  wire duty_ok  = (code <= `FAN_DUTY_MAX);
  wire fan_data = (state == st_fan_data) & wr_ev;
  wire bad_data = (fan_data & ~duty_ok) | ((state == st_no_data) & wr_ev);
  wire bad_cmd  = cmd_ev & ~known;
  wire no_fan   = (state == st_fan_data) & i_link.stop;

  always_comb begin
    next_state = state;
    if (cmd_ev) begin
      next_state = is_fan_set ? st_fan_data : st_no_data;
    end else if (i_link.stop | fan_data) begin
      next_state = fan_data ? st_no_data : st_idle;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= st_idle;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fan override

  logic       ovr_on;
  logic [7:0] ovr_duty;

  // Override set by a valid duty byte, dropped by fan-normal
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ovr_on   <= 1'b0;
      ovr_duty <= 8'h00;
    end else if (i_ce) begin
      if (cmd_ev & is_fan_nrm) begin
        ovr_on <= 1'b0;
      end else if (fan_data & duty_ok) begin
        ovr_on   <= 1'b1;
        ovr_duty <= code;
      end
    end
  end

  wire [7:0] next_duty = (ovr_on && ovr_duty > i_mon.thermal_duty) ? ovr_duty
                                                                    : i_mon.thermal_duty;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_fan_duty <= 8'h00;
    end else if (i_ce) begin
      o_fan_duty <= next_duty;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read response

  logic [7:0] resp [5];
  logic [2:0] resp_len;
  logic [2:0] resp_idx;

  // Response bytes captured when a read command arrives
  wire [2:0] next_len = is_input  ? 3'd4 :
                        is_fw     ? 3'd3 :
                        is_timer  ? 3'd3 :
                        is_fan_rd ? 3'd5 : 3'd0;
  wire [7:0] b0 = is_input  ? `INPUT_BYTE_COUNT :
                  is_fw     ? rev_byte(i_mon.fw_ok[2], i_mon.fw_rev[23:16]) :
                  is_timer  ? i_mon.run_hours[7:0] :
                              `FAN_BYTE_COUNT;
  wire [7:0] b1 = is_input  ? vin_byte(i_mon.vin_volts) :
                  is_fw     ? rev_byte(i_mon.fw_ok[1], i_mon.fw_rev[15:8]) :
                  is_timer  ? i_mon.run_hours[15:8] :
                              next_duty;
  wire [7:0] b2 = is_input  ? i_mon.pin_watts[7:0] :
                  is_fw     ? rev_byte(i_mon.fw_ok[0], i_mon.fw_rev[7:0]) :
                  is_timer  ? i_mon.run_hours[23:16] :
                              fan_byte(i_mon.fan_fitted[0], i_mon.fan_speed[7:0]);
  wire [7:0] b3 = is_input  ? i_mon.pin_watts[15:8] :
                              fan_byte(i_mon.fan_fitted[1], i_mon.fan_speed[15:8]);
  wire [7:0] b4 = fan_byte(i_mon.fan_fitted[2], i_mon.fan_speed[23:16]);

  wire       rd_hit  = i_link.rd & (resp_idx < resp_len);
  wire [7:0] rd_byte = rd_hit ? resp[resp_idx] : 8'h00;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      resp_len <= 3'd0;
      resp_idx <= 3'd0;
      for (int i = 0; i < 5; i++) begin
        resp[i] <= 8'h00;
      end
    end else if (i_ce) begin
      if (cmd_ev) begin
        resp_len <= next_len;
        resp_idx <= 3'd0;
        resp[0]  <= b0;
        resp[1]  <= b1;
        resp[2]  <= b2;
        resp[3]  <= b3;
        resp[4]  <= b4;
      end else if (rd_hit) begin
        resp_idx <= resp_idx + 3'd1;
      end
    end
  end

  // One byte answered the cycle after each read request
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rsp <= '0;
    end else if (i_ce) begin
      o_rsp.valid <= i_link.rd;
      o_rsp.last  <= i_link.rd & (resp_idx + 3'd1 >= resp_len);
      o_rsp.data  <= rd_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command side effects and timers

  logic hold_busy;
  logic settle_busy;

  cycle_timer #(.WIDTH(26)) u_hold (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_load    (cmd_ev & is_hold),
    .i_count   (26'(HOLD_CYCLES)),
    .o_busy    (hold_busy)
  );

  // Host-caused status changes are masked while the clear settles
  cycle_timer #(.WIDTH(26)) u_settle (
    .i_ref_clk (i_ref_clk),
    .i_rstn    (i_rstn),
    .i_ce      (i_ce),
    .i_load    (cmd_ev & is_clear),
    .i_count   (26'(SETTLE_CYC)),
    .o_busy    (settle_busy)
  );

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_iso_test_start <= 1'b0;
      o_clear_faults   <= 1'b0;
      o_scl_hold       <= 1'b0;
    end else if (i_ce) begin
      o_iso_test_start <= cmd_ev & is_iso;
      o_clear_faults   <= cmd_ev & is_clear;
      o_scl_hold       <= hold_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, fault pin and input indicator

  // Isolation result never reaches the fault pin; only internal faults do
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_status    <= 16'h0000;
      o_fault_pin <= 1'b0;
    end else if (i_ce) begin
      o_status    <= i_mon.status;
      o_fault_pin <= i_mon.internal_fault;
    end
  end

  logic [25:0] blink_cnt;
  logic        blink_ph;
  wire         blink_wrap = (blink_cnt == 26'(BLINK_CYCLES - 1));

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      blink_cnt <= 26'h000_0000;
      blink_ph  <= 1'b0;
    end else if (i_ce) begin
      blink_cnt <= blink_wrap ? 26'h000_0000 : blink_cnt + 26'h000_0001;
      blink_ph  <= blink_ph ^ blink_wrap;
    end
  end

  wire next_led = vin_pres & (vin_oor ? blink_ph : 1'b1);

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_input_led <= 1'b0;
    end else if (i_ce) begin
      o_input_led <= next_led;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alert

  logic        mains_q;
  logic        present_q;
  logic [15:0] status_q;
  logic        unsup;

  wire mains_rise   = mains_s & ~mains_q & ~aux_s;
  wire insert_rise  = present_s & ~present_q;
  wire status_chg   = (i_mon.status != status_q) & ~settle_busy &
                      ~i_mon.external_fault;
  wire error_ev     = bad_cmd | bad_data | no_fan;
  wire alert_set    = mains_rise | insert_rise | status_chg | error_ev;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mains_q   <= 1'b0;
      present_q <= 1'b0;
      status_q  <= 16'h0000;
    end else if (i_ce) begin
      mains_q   <= mains_s;
      present_q <= present_s;
      status_q  <= i_mon.status;
    end
  end

  // Set wins over the clear by a status read
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      unsup         <= 1'b0;
      o_smbalert_oe <= 1'b0;
      o_smbalert_o  <= 1'b0;
    end else if (i_ce) begin
      unsup         <= error_ev | (unsup & ~i_status_read);
      o_smbalert_oe <= alert_set | (o_smbalert_oe & ~i_status_read);
      o_smbalert_o  <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_unsupported <= 1'b0;
    end else if (i_ce) begin
      o_unsupported <= unsup;
    end
  end

endmodule

// file: testbench/rectifier_mgmt_properties.sv
// Checker of the management command unit, bound to its top module.
// Assumes i_ce stays high and the shared constants header is reachable.
`timescale 1ns/10ps
`include "rectifier_mgmt_consts.svh"

module rectifier_mgmt_checker #(
  parameter int HOLD_CYCLES = 20
) (
  input wire logic                          i_ref_clk,
  input wire logic                          i_rstn,
  input wire logic                          i_ce,
  input wire rectifier_mgmt_pkg::link_req_t i_link,
  input wire rectifier_mgmt_pkg::monitor_t  i_mon,
  input wire logic                          i_status_read,
  input wire rectifier_mgmt_pkg::link_rsp_t o_rsp,
  input wire logic [7:0]                    o_fan_duty,
  input wire logic [15:0]                   o_status,
  input wire logic                          o_unsupported,
  input wire logic                          o_scl_hold,
  input wire logic                          o_fault_pin,
  input wire logic                          o_smbalert_oe
);
  import rectifier_mgmt_pkg::*;

  logic [31:0] hold_len;
  logic        cmd_ok;
  logic        known;

  // Command decode seen from the link side
  assign cmd_ok = i_ce && i_link.cmd;
  assign known  = i_link.data inside {`CMD_CLEAR_FAULTS, `CMD_ISO_TEST, `CMD_READ_INPUT, `CMD_READ_FW_REV,
                                      `CMD_READ_RUN_TIMER, `CMD_FAN_SET, `CMD_FAN_NORMAL, `CMD_READ_FAN,
                                      `CMD_CLOCK_HOLD};

  // Length of the present clock hold
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) hold_len <= '0;
    else if (o_scl_hold) hold_len <= hold_len + 32'h0000_0001;
    else hold_len <= '0;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  ////////////////////////////////////////////////////////////
  property p_rsp_on_rd;
    i_ce && i_link.rd |=> o_rsp.valid;
  endproperty
  a_rsp_on_rd: assert property (p_rsp_on_rd) else $error("read byte missing");
  property p_rsp_caused;
    o_rsp.valid |-> $past(i_link.rd);
  endproperty
  a_rsp_caused: assert property (p_rsp_caused) else $error("read byte without request");
  property p_floor;
    $past(i_rstn) |-> o_fan_duty >= $past(i_mon.thermal_duty);
  endproperty
  a_floor: assert property (p_floor) else $error("fan duty below thermal demand");
  property p_normal;
    cmd_ok && i_link.data == `CMD_FAN_NORMAL |-> ##2 o_fan_duty == $past(i_mon.thermal_duty);
  endproperty
  a_normal: assert property (p_normal) else $error("fan normal kept override");
  property p_hold_start;
    cmd_ok && i_link.data == `CMD_CLOCK_HOLD |-> ##2 $rose(o_scl_hold);
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("clock hold did not start");
  property p_hold_len;
    $fell(o_scl_hold) |-> hold_len == HOLD_CYCLES;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("clock hold wrong length");
  property p_unsup;
    cmd_ok && !known |=> o_smbalert_oe ##1 o_unsupported;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unknown code not flagged");
  property p_oe_stands;
    o_smbalert_oe && !i_status_read |=> o_smbalert_oe;
  endproperty
  a_oe_stands: assert property (p_oe_stands) else $error("alert dropped without status read");
  property p_status;
    $past(i_rstn) |-> o_status == $past(i_mon.status);
  endproperty
  a_status: assert property (p_status) else $error("status not refreshed");
  property p_fault;
    o_fault_pin |-> $past(i_mon.internal_fault);
  endproperty
  a_fault: assert property (p_fault) else $error("fault pin without internal fault");
endmodule

bind rectifier_mgmt_command_unit rectifier_mgmt_checker #(.HOLD_CYCLES(HOLD_CYCLES))
  u_rectifier_mgmt_checker (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_link(i_link), .i_mon(i_mon),
  .i_status_read(i_status_read), .o_rsp(o_rsp), .o_fan_duty(o_fan_duty), .o_status(o_status),
  .o_unsupported(o_unsupported), .o_scl_hold(o_scl_hold), .o_fault_pin(o_fault_pin), .o_smbalert_oe(o_smbalert_oe));

// file: testbench/host_link_model.sv
// Host side of the management link: issues byte events, keeps read bytes.
// Assumes the unit samples on the rising edge of i_ref_clk.
`timescale 1ns/10ps
`include "rectifier_mgmt_consts.svh"

module host_link_model (
  input  wire logic                          i_ref_clk,
  input  wire rectifier_mgmt_pkg::link_rsp_t i_rsp,
  output rectifier_mgmt_pkg::link_req_t      o_link,
  output logic                               o_status_read
);
  import rectifier_mgmt_pkg::*;

  logic [8:0] got[$];

  // Read bytes kept with their last flag
  always @(posedge i_ref_clk) begin
    if (i_rsp.valid === 1'b1) got.push_back({i_rsp.last, i_rsp.data});
  end

  initial begin
    o_link = {4'h0, 8'hFF};
    o_status_read = 1'b0;
  end

  // One event a cycle, held until the taking edge
  task automatic send(input logic [3:0] kind, input logic [7:0] b);
    o_link = {kind, b};
    @(posedge i_ref_clk);
    #1;
  endtask

  // Stop, then data lines return to the idle value 8'hFF whatever the last byte was
  task automatic finish();
    send(4'b0001, 8'h00);
    o_link = {4'h0, 8'hFF};
  endtask

  // Command, optional written byte, reads, stop
  task automatic xfer(input logic [7:0] code, input int nwr, input logic [7:0] wb, input int nrd);
    got.delete();
    send(4'b1000, code);
    if (nwr > 0) send(4'b0100, wb);
    repeat (nrd) send(4'b0010, ~code);
    finish();
    repeat (2) @(posedge i_ref_clk);
    #1;
  endtask

  // Status read that releases a pending alert
  task automatic read_status();
    o_status_read = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_status_read = 1'b0;
  endtask

  // Isolation test with a wait before looking at the outcome
  task automatic iso_test(input int wait_cycles);
    xfer(`CMD_ISO_TEST, 0, 8'h00, 0);
    repeat (wait_cycles) @(posedge i_ref_clk);
    #1;
  endtask
endmodule

// file: testbench/tb_rectifier_mgmt_command_unit.sv
// Self-checking bench of the management command unit with a host model.
// Assumes the shared package and header and a 200 MHz reference clock.
`timescale 1ns/10ps
`include "rectifier_mgmt_consts.svh"

module tb_rectifier_mgmt_command_unit;
  import rectifier_mgmt_pkg::*;

  localparam int HOLD = 20;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        ce = 1'b1;
  logic        mains, aux_a, aux_b, present, vin_ok, vin_oor, st_rd;
  monitor_t    mon = '0;
  link_req_t   link;
  link_rsp_t   rsp;
  logic [7:0]  duty;
  logic [15:0] status;
  logic        unsup, iso, clr, hold, fault, led, al_o, al_oe;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          iso_n = 0;
  int          clr_n = 0;

  always #2.5 clk = ~clk;

  rectifier_mgmt_command_unit #(.HOLD_CYCLES(HOLD), .BLINK_CYCLES(8), .SETTLE_CYC(`CLEAR_SETTLE_CYC))
    u_rectifier_mgmt_command_unit (.i_ref_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_link(link), .i_mon(mon),
    .i_status_read(st_rd), .i_mains_ok(mains), .i_aux_bias_rail_a(aux_a), .i_aux_bias_rail_b(aux_b),
    .i_module_present(present), .i_vin_present(vin_ok), .i_vin_out_of_range(vin_oor), .o_rsp(rsp),
    .o_fan_duty(duty), .o_status(status), .o_unsupported(unsup), .o_iso_test_start(iso),
    .o_clear_faults(clr), .o_scl_hold(hold), .o_fault_pin(fault), .o_input_led(led),
    .o_smbalert_o(al_o), .o_smbalert_oe(al_oe));
  host_link_model u_host_link_model (.i_ref_clk(clk), .i_rsp(rsp), .o_link(link), .o_status_read(st_rd));

  // Pulse counters for one-cycle outputs
  always @(posedge clk) begin
    iso_n += int'(iso === 1'b1);
    clr_n += int'(clr === 1'b1);
  end

  ////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Read bytes in order, last flag on the final one only
  task automatic chk_bytes(input string what, input int n, input logic [39:0] exp);
    check({what, " count"}, 24'(n), 24'(u_host_link_model.got.size()));
    for (int i = 0; i < n; i++) begin
      check(what, {15'h0, i == n - 1, exp[8*(n-1-i) +: 8]}, 24'(u_host_link_model.got[i]));
    end
  endtask

  task automatic fan_set(input logic [7:0] v, input logic [7:0] e);
    u_host_link_model.xfer(`CMD_FAN_SET, 1, v, 0);
    check("fan duty", 24'(e), 24'(duty));
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_power();
    tick(6);
    check("alert power-up", 24'h1, 24'(al_oe));
    u_host_link_model.read_status();
    tick(1);
    check("alert released", 24'h0, 24'(al_oe));
    present = 1'b1;
    tick(6);
    check("alert insertion", 24'h1, 24'(al_oe));
    for (int k = 0; k < 2; k++) begin
      mains = 1'b0;
      {aux_a, aux_b} = k ? 2'b01 : 2'b10;
      tick(6);
      u_host_link_model.read_status();
      mains = 1'b1;
      tick(6);
      check("alert aux biased", 24'h0, 24'(al_oe));
    end
    {aux_a, aux_b} = 2'b00;
    mains = 1'b0;
    tick(6);
    mains = 1'b1;
    tick(6);
    check("alert mains return", 24'h1, 24'(al_oe));
  endtask

  task automatic t_reads();
    mon.vin_volts = 9'd300;
    mon.pin_watts = 16'h1234;
    mon.fw_ok = 3'b011;
    mon.fw_rev = 24'h33_2114;
    mon.run_hours = 24'h0A_0B0C;
    u_host_link_model.xfer(`CMD_READ_INPUT, 0, 8'h00, 4);
    chk_bytes("input", 4, {`INPUT_BYTE_COUNT, 8'(9'd300 - `VIN_OFFSET_V), 8'h34, 8'h12});
    u_host_link_model.xfer(`CMD_READ_FW_REV, 0, 8'h00, 3);
    chk_bytes("fw rev", 3, {`REV_NONE, 8'h21, 8'h14});
    u_host_link_model.xfer(`CMD_READ_RUN_TIMER, 0, 8'h00, 3);
    chk_bytes("hours", 3, 40'h00_0C0B_0A);
  endtask

  task automatic t_fan();
    u_host_link_model.read_status();
    mon.thermal_duty = 8'h30;
    mon.fan_fitted = 3'b101;
    mon.fan_speed = 24'h33_2211;
    fan_set(8'h50, 8'h50);
    u_host_link_model.xfer(`CMD_READ_FAN, 0, 8'h00, 5);
    chk_bytes("fan", 5, {`FAN_BYTE_COUNT, 8'h50, 8'h11, `FAN_ABSENT, 8'h33});
    fan_set(`FAN_DUTY_MAX, `FAN_DUTY_MAX);
    u_host_link_model.xfer(`CMD_FAN_NORMAL, 0, 8'h00, 0);
    check("duty normal", 24'h30, 24'(duty));
    fan_set(8'h20, 8'h30);
    mon.thermal_duty = 8'h10;
    tick(2);
    check("duty override", 24'h20, 24'(duty));
    fan_set(8'h65, 8'h20);
    check("alert bad data", 24'h1, 24'(al_oe));
  endtask

  task automatic t_unsup();
    for (int k = 0; k < 2; k++) begin
      u_host_link_model.read_status();
      u_host_link_model.xfer(k ? `CMD_FAN_NORMAL : 8'h55, k, 8'h01, 0);
      check("alert on error", 24'h1, 24'(al_oe));
      check("alert level", 24'h0, 24'(al_o));
      check("unsupported", 24'h1, 24'(unsup));
    end
    u_host_link_model.read_status();
    tick(2);
    check("unsupported cleared", 24'h0, 24'(unsup));
  endtask

  task automatic t_hold();
    int n = 0;
    u_host_link_model.send(4'b1000, `CMD_CLOCK_HOLD);
    u_host_link_model.finish();
    n += int'(hold === 1'b1);
    repeat (HOLD + 10) begin
      tick(1);
      n += int'(hold === 1'b1);
    end
    check("hold cycles", 24'(HOLD), 24'(n));
  endtask

  task automatic t_status();
    mon.status = 16'h0041;
    tick(3);
    check("status mirror", 24'h0041, 24'(status));
    check("alert status", 24'h1, 24'(al_oe));
    u_host_link_model.read_status();
    mon.external_fault = 1'b1;
    mon.status = 16'h0045;
    tick(3);
    check("alert external", 24'h0, 24'(al_oe));
    check("fault pin external", 24'h0, 24'(fault));
    mon.external_fault = 1'b0;
    mon.internal_fault = 1'b1;
    tick(2);
    check("fault pin internal", 24'h1, 24'(fault));
    mon.internal_fault = 1'b0;
    u_host_link_model.read_status();
    u_host_link_model.xfer(`CMD_CLEAR_FAULTS, 0, 8'h00, 0);
    mon.status = 16'h0000;
    tick(3);
    check("alert after clear", 24'h0, 24'(al_oe));
    check("clear pulses", 24'h1, 24'(clr_n));
    tick(`CLEAR_SETTLE_CYC);
    mon.status = 16'h0080;
    tick(3);
    check("alert later change", 24'h1, 24'(al_oe));
  endtask

  task automatic t_iso_led();
    int n = 0;
    logic prev;
    u_host_link_model.read_status();
    u_host_link_model.iso_test(30);
    check("iso start", 24'h1, 24'(iso_n));
    check("iso no fault", 24'h0, 24'({fault, al_oe}));
    vin_oor = 1'b1;
    prev = led;
    repeat (40) begin
      tick(1);
      n += int'(led !== prev);
      prev = led;
    end
    check("led blinks", 24'h1, 24'(n >= 2));
    vin_ok = 1'b0;
    tick(6);
    check("led off", 24'h0, 24'(led));
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    {mains, aux_a, aux_b, present, vin_ok, vin_oor} = 6'b100010;
    tick(3);
    rstn = 1'b1;
    t_power();
    t_reads();
    t_fan();
    t_unsup();
    t_hold();
    t_status();
    t_iso_led();
    close_out();
  end

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule
